/* hw/tcgcd_pkg.sv */
package tcgcd_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ARG_LOW    = 8'h0c;
    localparam logic [7:0] ADDR_COMMAND    = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h14;
    localparam logic [7:0] ADDR_AREA_BASE  = 8'h20;
    localparam int         AREA_BYTES      = 14;
    localparam logic [7:0] ADDR_AREA_LAST  = 8'h54;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_IDLE        = 8'h00;
    localparam logic [7:0] CMD_FACTORY_CAL = 8'h0a;
    localparam logic [7:0] CMD_DOWNLOAD    = 8'h0b;
    localparam logic [7:0] CMD_PIN_CTRL    = 8'h0f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_FACTORY_CAL  = 0;
    localparam int BIT_ALGO_STATE   = 1;
    localparam int PIN0_LSB         = 0;
    localparam int PIN1_LSB         = 4;
    localparam int ST_CAL_BUSY      = 0;
    localparam int ST_FACTORY       = 1;
    localparam int ST_ALGO          = 2;
    localparam int ST_PIN0_LEVEL    = 3;
    localparam int ST_PIN1_LEVEL    = 4;

    // ------------------------------------------------------------
    // general pin mode encoding
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_DISABLED   = 4'h0;
    localparam logic [3:0] MODE_IN_LOW     = 4'h1;
    localparam logic [3:0] MODE_IN_HIGH    = 4'h2;
    localparam logic [3:0] MODE_LASER      = 4'h3;
    localparam logic [3:0] MODE_DRIVE_LOW  = 4'h4;
    localparam logic [3:0] MODE_DRIVE_HIGH = 4'h5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;

endpackage : tcgcd_pkg

/* hw/tcgcd_pin.sv */
`timescale 1ns/10ps

// one general pin: input filter, stop/restart events and output driver
module tcgcd_pin (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // control
    input  wire logic [3:0] mode,
    input  wire logic       laser_pulse,
    // pin
    input  wire logic       pin_i,
    output logic            pin_o,
    output logic            pin_oe,
    // events
    output logic            level_q,
    output logic            abort_q,
    output logic            restart_q
);

    logic [2:0] sync_q;
    logic       level_d;
    logic       changed;

    // --------------------------------------------------------
    // three-stage input capture, level taken when stages 2, 3 agree
    // --------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sync_q <= 3'h7; // idle high, same as level_q, no false edge
        end else if (ce) begin
            sync_q <= {sync_q[1:0], pin_i};
        end
    end

    always_comb begin
        level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
        changed = (level_d != level_q);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            level_q <= 1'b1;
        end else if (ce) begin
            level_q <= level_d;
        end
    end

    // --------------------------------------------------------
    // collection stop and restart from the filtered level
    // --------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            abort_q   <= 1'b0;
            restart_q <= 1'b0;
        end else if (ce) begin
            abort_q   <= 1'b0;
            restart_q <= 1'b0;
            if (changed && mode == tcgcd_pkg::MODE_IN_LOW) begin
                abort_q   <= !level_d;
                restart_q <= level_d;
            end else if (changed && mode == tcgcd_pkg::MODE_IN_HIGH) begin
                abort_q   <= level_d;
                restart_q <= !level_d;
            end
        end
    end

    // --------------------------------------------------------
    // output driver, reserved codes behave as disabled
    // --------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else if (ce) begin
            unique case (mode)
                tcgcd_pkg::MODE_LASER: begin
                    pin_o  <= laser_pulse;
                    pin_oe <= 1'b1;
                end
                tcgcd_pkg::MODE_DRIVE_LOW: begin
                    pin_o  <= 1'b0;
                    pin_oe <= 1'b1;
                end
                tcgcd_pkg::MODE_DRIVE_HIGH: begin
                    pin_o  <= 1'b1;
                    pin_oe <= 1'b1;
                end
                default: begin
                    pin_o  <= 1'b0;
                    pin_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule : tcgcd_pin

/* hw/tcgcd_top.sv */
`timescale 1ns/10ps

// Behaviour
// - command 0x0A starts factory calibration in the measurement core.
// - calibration result is stored as 14 bytes from data area 0x20 up.
// - command 0x0B loads host data already written into the data area.
// - download argument bit 0 marks factory calibration present in area.
// - command 0x0F applies pin control without starting a measurement.
// - argument bits 3:0 set pin zero mode, bits 7:4 pin one mode.
// - mode 0 disabled, 3 laser pulse out, 4 drive low, 5 drive high.
// - mode 1 input low stops collection, return high restarts.
// - mode 2 input high stops collection, return low restarts.
module tcgcd_top (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // measurement core
    output logic              cal_start_q,
    input  wire logic         cal_done,
    input  wire logic [111:0] cal_result,
    output logic              dl_strobe_q,
    output logic              factory_cal_present_q,
    output logic              algo_state_present_q,
    output logic [111:0]      cal_area_q,
    input  wire logic         laser_pulse,
    output logic              meas_abort_q,
    output logic              meas_restart_q,
    // general pins
    input  wire logic         general_pin_zero_i,
    output logic              general_pin_zero_o,
    output logic              general_pin_zero_oe,
    input  wire logic         general_pin_one_i,
    output logic              general_pin_one_o,
    output logic              general_pin_one_oe
);

    logic [7:0] command_q;
    logic [7:0] arg_low_q;
    logic [7:0] pin_ctrl_q;
    logic       cal_busy_q;
    logic       wr_en;
    logic       rd_setup;
    logic       cmd_wr;
    logic       area_hit;
    logic [3:0] area_idx;
    logic [7:0] area_off;
    logic [31:0] rd_d;
    logic        err_d;
    logic [1:0]  pin_in;
    logic [1:0]  pin_o;
    logic [1:0]  pin_oe;
    logic [1:0]  pin_lvl;
    logic [1:0]  pin_abort;
    logic [1:0]  pin_restart;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a write is taken at the edge where psel, penable and pready meet; read data at the setup edge
    assign wr_en    = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;
    assign cmd_wr   = wr_en && paddr == tcgcd_pkg::ADDR_COMMAND;
    assign area_off = paddr - tcgcd_pkg::ADDR_AREA_BASE;
    assign area_hit = paddr >= tcgcd_pkg::ADDR_AREA_BASE
                   && paddr <= tcgcd_pkg::ADDR_AREA_LAST
                   && paddr[1:0] == 2'h0;
    assign area_idx = area_off[5:2];

    // read mux and error for the addressed word
    always_comb begin
        rd_d  = tcgcd_pkg::RST_WORD;
        err_d = 1'b0;
        if (area_hit) begin
            rd_d[7:0] = cal_area_q[area_idx*8 +: 8];
        end else begin
            unique case (paddr)
                tcgcd_pkg::ADDR_ARG_LOW: rd_d[7:0] = arg_low_q;
                tcgcd_pkg::ADDR_COMMAND: rd_d[7:0] = command_q;
                tcgcd_pkg::ADDR_STATUS: begin
                    rd_d[tcgcd_pkg::ST_CAL_BUSY]   = cal_busy_q;
                    rd_d[tcgcd_pkg::ST_FACTORY]    = factory_cal_present_q;
                    rd_d[tcgcd_pkg::ST_ALGO]       = algo_state_present_q;
                    rd_d[tcgcd_pkg::ST_PIN0_LEVEL] = pin_lvl[0];
                    rd_d[tcgcd_pkg::ST_PIN1_LEVEL] = pin_lvl[1];
                end
                default: err_d = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb answer: ready in the first access cycle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            prdata  <= tcgcd_pkg::RST_WORD;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= rd_setup;
            pslverr <= rd_setup && err_d;
            if (rd_setup && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    // ------------------------------------------------------------
    // argument byte
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            arg_low_q <= tcgcd_pkg::RST_BYTE;
        end else if (ce && wr_en && paddr == tcgcd_pkg::ADDR_ARG_LOW) begin
            arg_low_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // command register: held while calibration runs, else clears
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            command_q <= tcgcd_pkg::CMD_IDLE;
        end else if (ce) begin
            if (cmd_wr && !cal_busy_q) begin
                command_q <= pwdata[7:0];
            end else if (!cal_busy_q) begin
                command_q <= tcgcd_pkg::CMD_IDLE;
            end else if (cal_done) begin
                command_q <= tcgcd_pkg::CMD_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // factory calibration sequencing
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cal_busy_q  <= 1'b0;
            cal_start_q <= 1'b0;
        end else if (ce) begin
            cal_start_q <= 1'b0;
            if (cmd_wr && !cal_busy_q
                && pwdata[7:0] == tcgcd_pkg::CMD_FACTORY_CAL) begin
                cal_busy_q  <= 1'b1;
                cal_start_q <= 1'b1;
            end else if (cal_done) begin
                cal_busy_q  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // data area, one byte per word; calibration result wins
    // ------------------------------------------------------------
    for (genvar i = 0; i < tcgcd_pkg::AREA_BYTES; i++) begin : g_area
        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                cal_area_q[i*8 +: 8] <= tcgcd_pkg::RST_BYTE;
            end else if (ce) begin
                if (cal_busy_q && cal_done) begin
                    cal_area_q[i*8 +: 8] <= cal_result[i*8 +: 8];
                end else if (wr_en && area_hit && area_idx == i) begin
                    cal_area_q[i*8 +: 8] <= pwdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // download command: content flags and load strobe
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dl_strobe_q           <= 1'b0;
            factory_cal_present_q <= 1'b0;
            algo_state_present_q  <= 1'b0;
        end else if (ce) begin
            dl_strobe_q <= 1'b0;
            if (cmd_wr && !cal_busy_q
                && pwdata[7:0] == tcgcd_pkg::CMD_DOWNLOAD) begin
                dl_strobe_q           <= 1'b1;
                factory_cal_present_q <=
                    arg_low_q[tcgcd_pkg::BIT_FACTORY_CAL];
                // algorithm state is only valid with calibration present
                algo_state_present_q  <=
                    arg_low_q[tcgcd_pkg::BIT_ALGO_STATE]
                    && arg_low_q[tcgcd_pkg::BIT_FACTORY_CAL];
            end
        end
    end

    // ------------------------------------------------------------
    // pin control byte, kept until the next pin command
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pin_ctrl_q <= tcgcd_pkg::RST_BYTE;
        end else if (ce && cmd_wr && !cal_busy_q
                     && pwdata[7:0] == tcgcd_pkg::CMD_PIN_CTRL) begin
            pin_ctrl_q <= arg_low_q;
        end
    end

    // ------------------------------------------------------------
    // general pins
    // ------------------------------------------------------------
    assign pin_in = {general_pin_one_i, general_pin_zero_i};

    for (genvar p = 0; p < 2; p++) begin : g_pin
        tcgcd_pin u_pin (
            .sys_clk     (sys_clk),
            .rst_b       (rst_b),
            .ce          (ce),
            .mode        (pin_ctrl_q[p*4 +: 4]),
            .laser_pulse (laser_pulse),
            .pin_i       (pin_in[p]),
            .pin_o       (pin_o[p]),
            .pin_oe      (pin_oe[p]),
            .level_q     (pin_lvl[p]),
            .abort_q     (pin_abort[p]),
            .restart_q   (pin_restart[p])
        );
    end

    assign general_pin_zero_o  = pin_o[0];
    assign general_pin_zero_oe = pin_oe[0];
    assign general_pin_one_o   = pin_o[1];
    assign general_pin_one_oe  = pin_oe[1];

    // ------------------------------------------------------------
    // combined stop and restart towards the core
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meas_abort_q   <= 1'b0;
            meas_restart_q <= 1'b0;
        end else if (ce) begin
            meas_abort_q   <= |pin_abort;
            meas_restart_q <= |pin_restart && !(|pin_abort);
        end
    end

endmodule : tcgcd_top

/* sim/tcgcd_chk.sv */
`timescale 1ns/10ps

// watches the decoder ports and checks command and pin behaviour
module tcgcd_chk (
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rst_b,
    // apb
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic         pready,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    // measurement core
    input wire logic         cal_start_q,
    input wire logic         cal_done,
    input wire logic         dl_strobe_q,
    input wire logic         factory_cal_present_q,
    input wire logic         algo_state_present_q,
    input wire logic [111:0] cal_area_q,
    input wire logic         laser_pulse,
    input wire logic         meas_abort_q,
    // general pins
    input wire logic         general_pin_zero_o,
    input wire logic         general_pin_zero_oe,
    input wire logic         general_pin_one_o,
    input wire logic         general_pin_one_oe
);
    logic       wr;
    logic       cmd_a;
    logic       cmd_b;
    logic       cmd_f;
    logic [7:0] arg_q;
    logic [7:0] mode_q;
    logic [7:0] pm_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // completed writes and the commands they carry
    assign wr    = psel && penable && pready && pwrite;
    assign cmd_a = wr && paddr == 8'h10 && pwdata[7:0] == 8'h0a;
    assign cmd_b = wr && paddr == 8'h10 && pwdata[7:0] == 8'h0b;
    assign cmd_f = wr && paddr == 8'h10 && pwdata[7:0] == 8'h0f;

    // shadow of argument byte and of the pin modes seen at the pins
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            arg_q  <= 8'h00;
            mode_q <= 8'h00;
            pm_q   <= 8'h00;
        end else begin
            pm_q  <= mode_q; // pins follow one edge after the mode
            if (wr && paddr == 8'h0c) begin
                arg_q <= pwdata[7:0];
            end
            if (cmd_f) begin
                mode_q <= arg_q;
            end
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_cal_start;
        cal_start_q |-> $past(cmd_a) || $past(cmd_a, 2);
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration start without its command");
    property p_cal_area;
        $changed(cal_area_q) |-> $past(cal_done || (wr && paddr >= 8'h20));
    endproperty
    a_cal_area: assert property (p_cal_area)
        else $error("data area changed without a cause");
    property p_dl;
        dl_strobe_q |-> $past(cmd_b) || $past(cmd_b, 2);
    endproperty
    a_dl: assert property (p_dl)
        else $error("download strobe without its command");
    property p_flags;
        dl_strobe_q |=> factory_cal_present_q == arg_q[0]
            && algo_state_present_q == (arg_q[1] & arg_q[0]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("download flags differ from the mask");
    property p_algo;
        algo_state_present_q |-> factory_cal_present_q;
    endproperty
    a_algo: assert property (p_algo)
        else $error("algorithm flag without calibration flag");
    property p_pin_ctrl;
        cmd_f |-> ##1 !cal_start_q [*3];
    endproperty
    a_pin_ctrl: assert property (p_pin_ctrl)
        else $error("pin command started a calibration");
    property p_one_high;
        pm_q[7:4] == 4'h5 |-> general_pin_one_oe && general_pin_one_o;
    endproperty
    a_one_high: assert property (p_one_high)
        else $error("pin one not driven high");
    property p_low;
        pm_q[3:0] == 4'h4 |-> general_pin_zero_oe && !general_pin_zero_o;
    endproperty
    a_low: assert property (p_low)
        else $error("pin zero not driven low");
    property p_laser;
        pm_q[3:0] == 4'h3 |-> general_pin_zero_oe
            && general_pin_zero_o == $past(laser_pulse);
    endproperty
    a_laser: assert property (p_laser)
        else $error("pin zero does not follow the laser pulse");
    property p_off;
        pm_q[3:0] < 4'h3 |-> !general_pin_zero_oe;
    endproperty
    a_off: assert property (p_off)
        else $error("pin zero driven while off or input");
    property p_abort;
        meas_abort_q |-> pm_q[3:0] inside {4'h1, 4'h2}
            || pm_q[7:4] inside {4'h1, 4'h2};
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort while no pin is an input");
    property p_hold;
        $changed(general_pin_zero_oe) |-> $changed(pm_q[3:0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pin zero drive changed without a pin command");

    c_cal: cover property (cal_done);
    c_dl: cover property (dl_strobe_q);
    c_abort: cover property (meas_abort_q);
endmodule : tcgcd_chk

bind tcgcd_top tcgcd_chk u_chk (.*);

/* sim/tcgcd_core_model.sv */
`timescale 1ns/10ps

// measurement core stand-in: answers a calibration start after a delay
module tcgcd_core_model (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // calibration handshake
    input  wire logic         cal_start,
    input  wire logic [7:0]   delay,
    input  wire logic [111:0] result,
    output logic              cal_done,
    output logic [111:0]      cal_result
);
    logic [7:0] cnt_q;

    // count the calibration time, then pulse done with the result
    always_ff @(posedge sys_clk) begin
        cal_done   <= 1'b0;
        cal_result <= ~result; // result bus not valid outside done
        if (!rst_b) begin
            cnt_q <= 8'h00;
        end else if (cal_start) begin
            cnt_q <= delay;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
                cal_done   <= 1'b1;
                cal_result <= result;
            end
        end
    end
endmodule : tcgcd_core_model

/* sim/tcgcd_top_test.sv */
`timescale 1ns/10ps

`define CHK(nm, ex, gt) begin \
    tests_run++; \
    if ((gt) !== (ex)) begin \
        mismatches++; \
        $display("wrong value %s exp %h got %h", nm, ex, gt); \
    end \
end

module tcgcd_top_test;
    logic         sys_clk, rst_b, ce, psel, penable, pwrite, pready;
    logic         pslverr, cal_start_q, cal_done, dl_strobe_q, serr;
    logic         factory_cal_present_q, algo_state_present_q;
    logic         laser_pulse, meas_abort_q, meas_restart_q;
    logic         general_pin_zero_i, general_pin_zero_o;
    logic         general_pin_zero_oe, general_pin_one_i, g0_ext;
    logic         general_pin_one_o, general_pin_one_oe, g1_ext;
    logic [7:0]   paddr, dly, m;
    logic [31:0]  pwdata, prdata, rdat;
    logic [111:0] cal_result, cal_area_q, res;
    logic [7:0]   pins [4] = '{8'h54, 8'h45, 8'h03, 8'h30};
    int           mismatches, tests_run;

    // clock, design, core stand-in and pin wires
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    tcgcd_top dut (.*);
    tcgcd_core_model u_core (.sys_clk(sys_clk), .rst_b(rst_b),
        .cal_start(cal_start_q), .delay(dly), .result(res),
        .cal_done(cal_done), .cal_result(cal_result));
    assign general_pin_zero_i = general_pin_zero_oe ? general_pin_zero_o : g0_ext;
    assign general_pin_one_i  = general_pin_one_oe ? general_pin_one_o : g1_ext;

    task automatic report_and_stop;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // one apb transfer, waiting for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        @(posedge sys_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask : wr

    task automatic wait_ev(input logic k);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((k ? meas_restart_q : meas_abort_q) !== 1'b1 && n < 12);
        `CHK("stop event", 1'b1, k ? meas_restart_q : meas_abort_q)
        if ((k ? meas_restart_q : meas_abort_q) !== 1'b1) report_and_stop();
    endtask : wait_ev

    task automatic pin_chk(input logic [7:0] p);
        `CHK("pin0 oe", p[3:0] inside {4'h3, 4'h4, 4'h5}, general_pin_zero_oe)
        `CHK("pin1 oe", p[7:4] inside {4'h3, 4'h4, 4'h5}, general_pin_one_oe)
        if (p[3:0] > 4'h2) `CHK("pin0 lvl", p[3:0] != 4'h4, general_pin_zero_o)
        if (p[7:4] > 4'h2) `CHK("pin1 lvl", p[7:4] != 4'h4, general_pin_one_o)
    endtask : pin_chk

    // main sequence
    initial begin
        mismatches = 0;
        tests_run = 0;
        {ce, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {laser_pulse, g1_ext, res, dly} = '0;
        ce = 1'b1;
        g0_ext = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        apb(1'b0, 8'h08, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, serr)
        `CHK("unmapped data", 32'h0000_0000, rdat)
        // calibration answered promptly, then slowly
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 14; i++) res[8*i +: 8] = 8'h31 + 8'(i) + 8'(k * 64);
            dly = k ? 8'h3c : 8'h02;
            wr(8'h10, 8'h0a);
            for (int n = 0; n < 40; n++) begin
                apb(1'b0, 8'h14, 32'h0000_0000);
                if (rdat[0] === 1'b0) break;
            end
            `CHK("cal busy", 1'b0, rdat[0])
            if (rdat[0] !== 1'b0) report_and_stop();
            for (int i = 0; i < 14; i++) begin
                apb(1'b0, 8'h20 + 8'(4 * i), 32'h0000_0000);
                `CHK("cal byte", {24'h000000, res[8*i +: 8]}, rdat)
            end
        end
        // host fills the data area, then downloads with masks 0x01, 0x03 and 0x00
        for (int i = 0; i < 14; i++) begin
            res[8*i +: 8] = 8'ha0 + 8'(i);
            wr(8'h20 + 8'(4 * i), res[8*i +: 8]);
        end
        for (int j = 0; j < 3; j++) begin
            m = (j == 0) ? 8'h01 : (j == 1) ? 8'h03 : 8'h00;
            wr(8'h0c, m);
            wr(8'h10, 8'h0b);
            repeat (2) @(posedge sys_clk);
            `CHK("factory flag", m[0], factory_cal_present_q)
            `CHK("algo flag", m[1], algo_state_present_q)
            `CHK("area kept", res, cal_area_q)
        end
        // output modes on both pins, then a mode hold
        laser_pulse <= 1'b1;
        for (int j = 0; j < 4; j++) begin
            wr(8'h0c, pins[j]);
            wr(8'h10, 8'h0f);
            repeat (3) @(posedge sys_clk);
            pin_chk(pins[j]);
        end
        wr(8'h0c, 8'h55);
        repeat (3) @(posedge sys_clk);
        pin_chk(8'h30);
        laser_pulse <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("laser out", 1'b0, general_pin_one_o)
        // pin zero stops on low, pin one stops on high
        wr(8'h0c, 8'h21);
        wr(8'h10, 8'h0f);
        repeat (8) @(posedge sys_clk);
        g0_ext <= 1'b0;
        wait_ev(1'b0);
        g0_ext <= 1'b1;
        wait_ev(1'b1);
        g1_ext <= 1'b1;
        wait_ev(1'b0);
        g1_ext <= 1'b0;
        wait_ev(1'b1);
        report_and_stop();
    end
endmodule : tcgcd_top_test
